// *** src/timer16.sv ***
// sixteen bit timer with output compare, input capture and pwm
// Summary of operation
// - internal tick period selectable two to eight cycles
// - capture pulses of one cycle are recognised
// - stop during compare event locks compare flag
// - locked flag with enable keeps interrupt asserted
// - status bit 0x40 stops, clearing restarts timer
// - control bit 0x40 enables compare interrupt
`timescale 1ns/10ps
`default_nettype none
module timer16 #(
    parameter int WIDTH = 16 // counter width
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control bytes as software writes them
    input wire logic [7:0] i_control_one,
    input wire logic [7:0] i_control_status,
    input wire logic [1:0] i_clk_sel,
    // compare setup and flag clear
    input wire logic [WIDTH-1:0] i_compare_value,
    input wire logic i_oc_flag_clear,
    // capture pin and flag clear
    input wire logic i_input_capture,
    input wire logic i_capture_rising,
    input wire logic i_ic_flag_clear,
    // pwm setup
    input wire logic i_pwm_enable,
    input wire logic [WIDTH-1:0] i_pwm_period,
    input wire logic [WIDTH-1:0] i_pwm_duty,
    // counter and flags
    output logic [WIDTH-1:0] o_count,
    output logic o_oc_flag,
    output logic o_ic_flag,
    output logic [WIDTH-1:0] o_capture_value,
    output logic o_irq,
    // pins
    output logic o_output_compare,
    output logic o_pwm
);
    logic run; // timer running
    logic tick; // one cycle per counter step
    logic stop_bit; // stop bit from the status byte
    logic stop_prev; // stop bit one cycle ago
    logic oc_irq_en; // compare interrupt enable
    logic oc_event; // compare match on this tick

    // control decode
    assign stop_bit = i_control_status[timer16_pkg::CTRL_STATUS_STOP_POS];
    assign oc_irq_en = i_control_one[timer16_pkg::CTRL_ONE_OC_IRQ_EN_POS];
    assign run = !stop_bit;

    // tick source
    tick_prescaler u_prescaler (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(run),
        .i_clk_sel(i_clk_sel),
        .o_tick(tick)
    );

    // ---------------- counter and compare ----------------
    logic [WIDTH-1:0] count; // free running count
    logic [WIDTH-1:0] next_count;
    logic oc_flag; // compare flag
    logic next_oc_flag;
    logic oc_lock; // flag locked by a stop during a match
    logic next_oc_lock;
    logic oc_pin; // compare output pin, toggles on match
    logic next_oc_pin;
    logic irq; // interrupt request
    logic next_irq;
    logic next_stop_prev;

    // a tick can still arrive in the cycle the stop bit rises, so the match
    // and the stop meet here; that is the case that freezes the flag
    always_comb begin
        next_count = count;
        next_oc_flag = oc_flag;
        next_oc_lock = oc_lock;
        next_oc_pin = oc_pin;
        next_stop_prev = stop_bit;
        oc_event = 1'b0;
        if (tick) begin
            next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
            oc_event = (next_count == i_compare_value);
        end
        // lock released only once the timer runs again
        if (!stop_bit) begin
            next_oc_lock = 1'b0;
        end
        if (oc_event && stop_bit && !stop_prev) begin
            next_oc_lock = 1'b1;
        end
        // clear is ignored while locked; a new match wins over a clear
        if (i_oc_flag_clear && !oc_lock) begin
            next_oc_flag = 1'b0;
        end
        if (oc_event) begin
            next_oc_flag = 1'b1;
            next_oc_pin = !oc_pin;
        end
        // stuck flag keeps the request up while the enable is set
        next_irq = next_oc_flag && oc_irq_en;
    end

    // register counter and compare state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= timer16_pkg::COUNT_RESET;
            oc_flag <= 1'b0;
            oc_lock <= 1'b0;
            oc_pin <= 1'b0;
            irq <= 1'b0;
            stop_prev <= 1'b0;
        end else begin
            count <= next_count;
            oc_flag <= next_oc_flag;
            oc_lock <= next_oc_lock;
            oc_pin <= next_oc_pin;
            irq <= next_irq;
            stop_prev <= next_stop_prev;
        end
    end

    // ---------------- input capture ----------------
    logic [2:0] ic_sync; // synchroniser chain, bit 0 meets the pin
    logic [2:0] next_ic_sync;
    logic ic_flag; // capture flag
    logic next_ic_flag;
    logic [WIDTH-1:0] capture; // captured count
    logic [WIDTH-1:0] next_capture;
    logic ic_edge; // chosen edge seen between stages two and three

    // the edge is taken between the second and third stage so that a pulse
    // of only one cycle still registers; the first stage is never inspected
    always_comb begin
        next_ic_sync = {ic_sync[1:0], i_input_capture};
        next_ic_flag = ic_flag;
        next_capture = capture;
        if (i_capture_rising) begin
            ic_edge = ic_sync[1] && !ic_sync[2];
        end else begin
            ic_edge = !ic_sync[1] && ic_sync[2];
        end
        if (i_ic_flag_clear) begin
            next_ic_flag = 1'b0;
        end
        // a capture in the clear cycle wins
        if (ic_edge) begin
            next_ic_flag = 1'b1;
            next_capture = count;
        end
    end

    // register capture state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ic_sync <= 3'h0;
            ic_flag <= 1'b0;
            capture <= timer16_pkg::CAPTURE_RESET;
        end else begin
            ic_sync <= next_ic_sync;
            ic_flag <= next_ic_flag;
            capture <= next_capture;
        end
    end

    // ---------------- pwm ----------------
    logic [WIDTH-1:0] pwm_count; // ticks into the current pwm period
    logic [WIDTH-1:0] next_pwm_count;
    logic [WIDTH-1:0] pwm_last; // last tick of the period, clamped
    logic pwm; // pwm pin level
    logic next_pwm;

    // a period of one tick would repeat every two cycles; clamping to two
    // ticks keeps the rate at a quarter of the cpu clock at the most
    always_comb begin
        if (i_pwm_period < WIDTH'(timer16_pkg::PWM_MIN_PERIOD)) begin
            pwm_last = WIDTH'(timer16_pkg::PWM_MIN_PERIOD);
        end else begin
            pwm_last = i_pwm_period;
        end
        next_pwm_count = pwm_count;
        next_pwm = pwm;
        if (!i_pwm_enable) begin
            next_pwm_count = {WIDTH{1'b0}};
            next_pwm = 1'b0;
        end else if (tick) begin
            // while enabled, level moves only on ticks, never finer than two cycles; disabling drops it low in any cycle
            if (pwm_count >= pwm_last) begin
                next_pwm_count = {WIDTH{1'b0}};
            end else begin
                next_pwm_count = pwm_count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
            next_pwm = (next_pwm_count < i_pwm_duty);
        end
    end

    // register pwm state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pwm_count <= {WIDTH{1'b0}};
            pwm <= 1'b0;
        end else begin
            pwm_count <= next_pwm_count;
            pwm <= next_pwm;
        end
    end

    // outputs straight from flip-flops
    assign o_count = count;
    assign o_oc_flag = oc_flag;
    assign o_ic_flag = ic_flag;
    assign o_capture_value = capture;
    assign o_irq = irq;
    assign o_output_compare = oc_pin;
    assign o_pwm = pwm;
endmodule : timer16
`default_nettype wire

// *** src/timer16_pkg.sv ***
// constants shared by the sixteen bit compare/capture timer
package timer16_pkg;
    // clock period of the cpu clock feeding the timer, in picoseconds
    localparam int CLK_PERIOD_PS = 4000;
    // tick period choices, in cpu clock periods
    localparam int TICK_DIV_MIN = 2;
    localparam int TICK_DIV_MID = 4;
    localparam int TICK_DIV_MAX = 8;
    // tick select codes on the clock select input
    localparam logic [1:0] CLK_SEL_DIV2 = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV4 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV8 = 2'h2;
    // bit positions inside the two control bytes
    localparam int CTRL_ONE_OC_IRQ_EN_POS = 6;
    localparam int CTRL_STATUS_STOP_POS = 6;
    // least pwm period, in ticks minus one (two ticks at the least)
    localparam logic [15:0] PWM_MIN_PERIOD = 16'h0001;
    // reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [2:0] DIV_COUNT_RESET = 3'h0;
endpackage : timer16_pkg

// *** src/tick_prescaler.sv ***
// prescaler that turns the cpu clock into counter ticks
`timescale 1ns/10ps
`default_nettype none
module tick_prescaler (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_run,
    input wire logic [1:0] i_clk_sel,
    // tick out, one cycle wide
    output logic o_tick
);
    logic [2:0] div_count; // cycles since the last tick
    logic [2:0] next_div_count;
    logic tick; // registered tick
    logic next_tick;
    logic [2:0] last; // terminal count for the chosen divider

    // pick terminal count; unknown codes fall back to the slowest rate
    always_comb begin
        unique case (i_clk_sel)
            timer16_pkg::CLK_SEL_DIV2: last = 3'(timer16_pkg::TICK_DIV_MIN - 1);
            timer16_pkg::CLK_SEL_DIV4: last = 3'(timer16_pkg::TICK_DIV_MID - 1);
            default: last = 3'(timer16_pkg::TICK_DIV_MAX - 1);
        endcase
    end

    // next divider count; held at zero while stopped so restart is clean
    always_comb begin
        next_div_count = div_count;
        next_tick = 1'b0;
        if (!i_run) begin
            next_div_count = timer16_pkg::DIV_COUNT_RESET;
        end else if (div_count >= last) begin
            next_div_count = timer16_pkg::DIV_COUNT_RESET;
            next_tick = 1'b1;
        end else begin
            next_div_count = div_count + 3'h1;
        end
    end

    // register divider state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_count <= timer16_pkg::DIV_COUNT_RESET;
            tick <= 1'b0;
        end else begin
            div_count <= next_div_count;
            tick <= next_tick;
        end
    end

    assign o_tick = tick;
endmodule : tick_prescaler
`default_nettype wire

// *** verif/timer16_chk.sv ***
// concurrent checks on the compare/capture timer ports
`timescale 1ns/10ps
`default_nettype none
module timer16_chk #(
    parameter int WIDTH = 16 // counter width
) (
    // watched ports
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_control_one,
    input wire logic [7:0] i_control_status,
    input wire logic i_input_capture,
    input wire logic i_capture_rising,
    input wire logic [WIDTH-1:0] o_count,
    input wire logic o_oc_flag,
    input wire logic o_ic_flag,
    input wire logic o_irq,
    input wire logic o_pwm
);
    // one domain, so one clock and one disable for all
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_irq_from_flag: assert property (o_irq == (o_oc_flag & $past(i_control_one[6])))
        else $error("irq differs from flag and enable");
    chk_irq_masked: assert property (!i_control_one[6] |=> !o_irq)
        else $error("irq high with enable low");
    chk_count_step: assert property ($changed(o_count) |-> o_count == $past(o_count) + 1'b1)
        else $error("counter moved by other than one");
    chk_tick_spacing: assert property ($changed(o_count) |=> $stable(o_count))
        else $error("ticks closer than two cycles");
    chk_stop_holds: assert property (i_control_status[6] && $past(i_control_status[6]) |=> $stable(o_count))
        else $error("counter moved while stopped");
    // a match landing on the stop edge must leave the flag up
    chk_flag_locked: assert property ($rose(o_oc_flag) && $past(i_control_status[6])
        && !$past(i_control_status[6], 2) |=> o_oc_flag)
        else $error("locked compare flag dropped");
    chk_capture_seen: assert property ($rose(i_input_capture) && i_capture_rising |-> ##[1:5] o_ic_flag)
        else $error("capture pulse missed");
    chk_pwm_rate: assert property ($rose(o_pwm) |=> (!$rose(o_pwm)) [*3])
        else $error("pwm period under four cycles");
    chk_pwm_grain: assert property ($changed(o_pwm) |=> $stable(o_pwm))
        else $error("pwm edges closer than two cycles");
endmodule : timer16_chk
bind timer16 timer16_chk #(.WIDTH(WIDTH)) i_timer16_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_control_one(i_control_one), .i_control_status(i_control_status), .i_input_capture(i_input_capture),
    .i_capture_rising(i_capture_rising), .o_count(o_count), .o_oc_flag(o_oc_flag), .o_ic_flag(o_ic_flag),
    .o_irq(o_irq), .o_pwm(o_pwm));
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the compare/capture timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // stimulus, all driven by the bench
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_control_one = 8'h00;
    logic [7:0] i_control_status = 8'h00;
    logic [1:0] i_clk_sel = 2'h0;
    logic [15:0] i_compare_value = 16'h0000;
    logic i_oc_flag_clear = 1'b0;
    logic i_input_capture = 1'b0;
    logic i_capture_rising = 1'b1;
    logic i_ic_flag_clear = 1'b0;
    logic i_pwm_enable = 1'b0;
    logic [15:0] i_pwm_period = 16'h0000;
    logic [15:0] i_pwm_duty = 16'h0000;
    // observed outputs
    logic [15:0] o_count;
    logic [15:0] o_capture_value;
    logic o_oc_flag, o_ic_flag, o_irq, o_output_compare, o_pwm;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2 i_clk = ~i_clk;
    timer16 #(.WIDTH(16)) i_timer16 (.i_clk(i_clk), .i_rst(i_rst), .i_control_one(i_control_one),
        .i_control_status(i_control_status), .i_clk_sel(i_clk_sel), .i_compare_value(i_compare_value),
        .i_oc_flag_clear(i_oc_flag_clear), .i_input_capture(i_input_capture),
        .i_capture_rising(i_capture_rising), .i_ic_flag_clear(i_ic_flag_clear), .i_pwm_enable(i_pwm_enable),
        .i_pwm_period(i_pwm_period), .i_pwm_duty(i_pwm_duty), .o_count(o_count), .o_oc_flag(o_oc_flag),
        .o_ic_flag(o_ic_flag), .o_capture_value(o_capture_value), .o_irq(o_irq),
        .o_output_compare(o_output_compare), .o_pwm(o_pwm));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // count cycles between two counter ticks for every divider code
    task automatic t_prescale;
        int n;
        int e;
        logic [15:0] c;
        for (int s = 0; s < 4; s++) begin
            @(posedge i_clk) i_clk_sel <= s[1:0];
            repeat (20) @(posedge i_clk);
            #1 c = o_count;
            while (o_count === c) @(posedge i_clk) #1;
            c = o_count;
            n = 0;
            while (o_count === c) begin
                @(posedge i_clk);
                #1 n++;
            end
            // code 3 runs at the slowest rate like code 2
            e = (s == 0) ? timer16_pkg::TICK_DIV_MIN
                : (s == 1) ? timer16_pkg::TICK_DIV_MID : timer16_pkg::TICK_DIV_MAX;
            check(16'(n), 16'(e));
            check(o_count, c + 16'h0001);
        end
        $display("prescale test done");
    endtask : t_prescale
    // one-cycle pin pulse in both edge senses
    task automatic t_capture;
        for (int m = 0; m < 2; m++) begin
            @(posedge i_clk) begin
                i_capture_rising <= m[0];
                i_input_capture <= ~m[0];
                i_ic_flag_clear <= 1'b1;
            end
            repeat (6) @(posedge i_clk) i_ic_flag_clear <= 1'b0;
            i_input_capture <= m[0];
            @(posedge i_clk) i_input_capture <= ~m[0];
            repeat (5) @(posedge i_clk);
            #1 check(o_ic_flag, 1'b1);
            // captured count must be recent, at most one tick behind the live count
            check(16'(o_count - o_capture_value <= 16'h0001), 16'h0001);
        end
        $display("capture test done");
    endtask : t_capture
    // stop lands exactly on the compare match, irq enabled first on purpose
    task automatic t_lock;
        logic [15:0] c;
        @(posedge i_clk) begin
            i_clk_sel <= 2'h0;
            i_compare_value <= o_count + 16'h0010;
            i_control_one <= 8'h40;
        end
        #1 c = i_compare_value - 16'h0001;
        while (o_count !== c) @(posedge i_clk) #1;
        // stop with the interrupt still enabled, the unsafe order, to provoke the lock
        @(posedge i_clk) i_control_status <= 8'h40;
        repeat (3) @(posedge i_clk) i_oc_flag_clear <= 1'b1;
        @(posedge i_clk) i_oc_flag_clear <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1 c = o_count;
        check(o_oc_flag, 1'b1);
        check(o_irq, 1'b1);
        check(o_count, i_compare_value);
        check(o_output_compare, 1'b1);
        @(posedge i_clk) i_control_one <= 8'h00;
        repeat (2) @(posedge i_clk);
        #1 check(o_irq, 1'b0);
        // restart in the safe order: timer first, interrupt enable afterwards
        @(posedge i_clk) i_control_status <= 8'h00;
        repeat (3) @(posedge i_clk) i_control_one <= 8'h40;
        repeat (2) @(posedge i_clk) i_oc_flag_clear <= 1'b1;
        @(posedge i_clk) i_oc_flag_clear <= 1'b0;
        #1 check(o_oc_flag, 1'b0);
        check(o_irq, 1'b0);
        check(16'(o_count == c), 16'h0000);
        $display("compare lock test done");
    endtask : t_lock
    // period below the floor, then four ticks with two high: lengths in cycles
    task automatic t_pwm;
        int hi;
        int per;
        for (int p = 0; p < 2; p++) begin
            @(posedge i_clk) begin
                i_pwm_enable <= 1'b1;
                i_pwm_period <= (p == 0) ? 16'h0000 : 16'h0003;
                i_pwm_duty <= (p == 0) ? 16'h0001 : 16'h0002;
            end
            repeat (8) @(posedge i_clk);
            #1 while (o_pwm !== 1'b0) @(posedge i_clk) #1;
            while (o_pwm !== 1'b1) @(posedge i_clk) #1;
            hi = 0;
            while (o_pwm === 1'b1) begin
                @(posedge i_clk);
                #1 hi++;
            end
            per = hi;
            while (o_pwm === 1'b0) begin
                @(posedge i_clk);
                #1 per++;
            end
            check(16'(hi), (p == 0) ? 16'h0002 : 16'h0004);
            check(16'(per), (p == 0) ? 16'h0004 : 16'h0008);
        end
        $display("pwm test done");
    endtask : t_pwm
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // cut a hang short
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_prescale();
        t_capture();
        t_lock();
        t_pwm();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
